// >>> common/l2c_pkg.sv
package l2c_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int IDX_W = 15;
  localparam int TAG_W = 19;
  localparam int TAG_LSB = 13;
  localparam int LINE_LSB = 5;
  localparam int ENT_W = 21;
  localparam int ENT_VALID = 20;
  localparam int ENT_DIRTY = 19;
  localparam int CNT_W = 4;
  localparam logic [1:0] SIZE_256K = 2'h0;
  localparam logic [1:0] SIZE_512K = 2'h1;
  localparam logic [1:0] SIZE_1M = 2'h2;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [CNT_W-1:0] LEAD_NP = 4'h3;
  localparam logic [CNT_W-1:0] LEAD_PIPE = 4'h2;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_LOOK = 6'h02,
    D_BURST = 6'h04,
    D_CAST = 6'h08,
    D_MISS = 6'h10,
    D_SNOOP = 6'h20
  } l2c_state_e;

  function automatic logic [IDX_W-1:0] l2c_index(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
    logic [IDX_W-1:0] m;
    m = a[LINE_LSB+IDX_W-1:LINE_LSB];
    if (sz == SIZE_256K) begin
      m[IDX_W-1:IDX_W-2] = 2'h0;
    end else if (sz == SIZE_512K) begin
      m[IDX_W-1] = 1'b0;
    end
    return m;
  endfunction

  function automatic logic l2c_hit(input logic [ENT_W-1:0] e, input logic [ADDR_W-1:0] a);
    return e[ENT_VALID] && (e[TAG_W-1:0] == a[ADDR_W-1:TAG_LSB]);
  endfunction

  function automatic logic [ENT_W-1:0] l2c_entry(input logic v, input logic d, input logic [TAG_W-1:0] t);
    return {v, d, t};
  endfunction
endpackage

// >>> common/l2c_arb_if.sv
interface l2c_arb_if;
  logic [1:0] req;
  logic abus_free;
  logic ts;
  logic dbusy;
  logic downer;
  logic [1:0] agnt;
  logic [1:0] dgnt;
  logic aowner;
  modport arb(input req, abus_free, ts, dbusy, downer, output agnt, dgnt, aowner);
  modport ctrl(output req, abus_free, ts, dbusy, downer, input agnt, dgnt, aowner);
endinterface

// >>> rtl/l2c_arb.sv
module l2c_arb #(
  parameter logic PARK = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  l2c_arb_if.arb bus
);
  import l2c_pkg::*;

  logic owner;
  logic next_owner;

  // Round robin while the address slot is free and no address is acknowledged, otherwise the owner holds.
  always_comb begin
    next_owner = owner;
    if (bus.abus_free && !bus.ts) begin
      if (bus.req[~owner]) begin
        next_owner = ~owner;
      end else if (!bus.req[owner]) begin
        next_owner = PARK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      owner <= PARK;
    end else if (ce_i) begin
      owner <= next_owner;
    end
  end

  assign bus.aowner = owner;
  assign bus.agnt = bus.abus_free ? (owner ? 2'h2 : 2'h1) : 2'h0;
  assign bus.dgnt = (bus.dbusy ? bus.downer : PARK) ? 2'h2 : 2'h1;
endmodule // l2c_arb

// >>> rtl/l2c_ctrl.sv
module l2c_ctrl #(
  parameter logic PARK_OWNER = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic cfg_wb_mode_i,
  input wire logic [1:0] cfg_size_i,
  input wire logic [l2c_pkg::CNT_W-1:0] cfg_tag_wait_i,
  input wire logic [1:0] br_i,
  output logic [1:0] bg_o,
  output logic [1:0] dbg_o,
  input wire logic ts_i,
  input wire logic [l2c_pkg::ADDR_W-1:0] addr_i,
  input wire logic write_i,
  output logic aack_o,
  output logic ta_o,
  output logic [l2c_pkg::DATA_W-1:0] rdata_o,
  input wire logic [l2c_pkg::DATA_W-1:0] wdata_i,
  output logic [l2c_pkg::IDX_W-1:0] tag_addr_o,
  input wire logic [l2c_pkg::ENT_W-1:0] tag_rdata_i,
  output logic tag_we_o,
  output logic [l2c_pkg::ENT_W-1:0] tag_wdata_o,
  output logic [l2c_pkg::IDX_W+1:0] sram_addr_o,
  output logic sram_we_o,
  output logic [l2c_pkg::DATA_W-1:0] sram_wdata_o,
  input wire logic [l2c_pkg::DATA_W-1:0] sram_rdata_i,
  output logic mem_start_o,
  output logic [l2c_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_write_o,
  output logic mem_abort_o,
  output logic mem_wvalid_o,
  output logic mem_castout_o,
  output logic [l2c_pkg::ADDR_W-1:0] mem_cast_addr_o,
  output logic [l2c_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [l2c_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic snoop_req_i,
  input wire logic [l2c_pkg::ADDR_W-1:0] snoop_addr_i,
  input wire logic snoop_inv_i,
  output logic snoop_ack_o,
  output logic snoop_hit_o,
  output logic snoop_dirty_o
);
  import l2c_pkg::*;

  l2c_state_e st;
  logic [CNT_W-1:0] cnt;
  logic [1:0] beat;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] pend_addr;
  logic [ADDR_W-1:0] snp_addr;
  logic cur_write;
  logic cur_owner;
  logic pend_v;
  logic pend_write;
  logic pend_owner;
  logic snp_inv;
  logic [TAG_W-1:0] vtag;
  logic [DATA_W-1:0] rbuf;
  logic rd_ack_q;
  logic mem_start_q;
  logic mem_abort_q;
  logic snp_ack_q;
  logic snp_hit_q;
  logic snp_dirty_q;
  logic start;
  logic last_beat;
  logic decide;
  logic hit;
  logic snp_hit;
  logic victim_dirty;
  logic [IDX_W-1:0] cur_idx;
  logic [1:0] sbeat;
  logic snp_take;

  l2c_arb_if arb_if ();

  l2c_arb #(.PARK(PARK_OWNER)) u_arb (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .bus(arb_if.arb)
  );

  // Only one address may wait behind the running data phase, so the grant drops while it is held.
  assign aack_o = ts_i && !pend_v;
  assign arb_if.req = br_i;
  assign arb_if.abus_free = !pend_v;
  assign arb_if.ts = aack_o;
  assign arb_if.dbusy = (st != D_IDLE) && (st != D_SNOOP);
  assign arb_if.downer = cur_owner;
  assign bg_o = arb_if.agnt;
  assign dbg_o = arb_if.dgnt;

  assign cur_idx = l2c_index(cur_addr, cfg_size_i);
  assign hit = l2c_hit(tag_rdata_i, cur_addr);
  assign snp_hit = l2c_hit(tag_rdata_i, snp_addr);
  assign decide = (st == D_LOOK) && (cnt == 4'h1);
  assign victim_dirty = cfg_wb_mode_i && !cur_write && tag_rdata_i[ENT_VALID] && tag_rdata_i[ENT_DIRTY];
  assign last_beat = (beat == LAST_BEAT) && ((st == D_BURST) || ((st == D_MISS) && mem_ack_i));
  assign start = (pend_v || ts_i) && (((st == D_IDLE) && !snoop_req_i) || last_beat);
  // A snoop request still held in the cycle of its answer is not taken a second time.
  assign snp_take = (st == D_IDLE) && snoop_req_i && !snp_ack_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= D_IDLE;
      beat <= 2'h0;
    end else if (ce_i) begin
      unique case (st)
        D_IDLE: begin
          if (snp_take) begin
            st <= D_SNOOP;
          end else if (start) begin
            st <= D_LOOK;
          end
        end
        D_SNOOP: st <= D_IDLE;
        D_LOOK: begin
          if (decide) begin
            if (hit) begin
              st <= D_BURST;
            end else if (victim_dirty) begin
              st <= D_CAST;
            end else begin
              st <= D_MISS;
            end
          end
        end
        D_BURST: begin
          beat <= beat + 2'h1;
          if (beat == LAST_BEAT) begin
            st <= start ? D_LOOK : D_IDLE;
          end
        end
        D_CAST: begin
          if (mem_ack_i) begin
            beat <= beat + 2'h1;
            if (beat == LAST_BEAT) begin
              st <= D_MISS;
            end
          end
        end
        D_MISS: begin
          if (mem_ack_i) begin
            beat <= beat + 2'h1;
            if (beat == LAST_BEAT) begin
              st <= start ? D_LOOK : D_IDLE;
            end
          end
        end
      endcase
    end
  end

  // The lead count covers the tag access; extra wait states suit slower tag parts.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (start) begin
        cnt <= (last_beat ? LEAD_PIPE : LEAD_NP) - 4'h1 + cfg_tag_wait_i;
      end else if ((st == D_LOOK) && !decide) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend_v <= 1'b0;
      pend_addr <= '0;
      pend_write <= 1'b0;
      pend_owner <= 1'b0;
    end else if (ce_i) begin
      if (start && pend_v) begin
        pend_v <= 1'b0;
      end else if (aack_o && !start) begin
        pend_v <= 1'b1;
        pend_addr <= addr_i;
        pend_write <= write_i;
        pend_owner <= arb_if.aowner;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cur_addr <= '0;
      cur_write <= 1'b0;
      cur_owner <= 1'b0;
    end else if (ce_i && start) begin
      cur_addr <= pend_v ? pend_addr : addr_i;
      cur_write <= pend_v ? pend_write : write_i;
      cur_owner <= pend_v ? pend_owner : arb_if.aowner;
    end
  end

  // Memory is started with the lookup instead of after it, which hides the tag time on a miss.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mem_start_q <= 1'b0;
      mem_abort_q <= 1'b0;
      vtag <= '0;
    end else if (ce_i) begin
      mem_start_q <= start;
      mem_abort_q <= decide && hit && !(cur_write && !cfg_wb_mode_i);
      if (decide) begin
        vtag <= tag_rdata_i[TAG_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rbuf <= '0;
      rd_ack_q <= 1'b0;
    end else if (ce_i) begin
      rd_ack_q <= (st == D_MISS) && !cur_write && mem_ack_i;
      if ((decide && hit) || (st == D_BURST)) begin
        rbuf <= sram_rdata_i;
      end else if ((st == D_MISS) && mem_ack_i) begin
        rbuf <= mem_rdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      snp_addr <= '0;
      snp_inv <= 1'b0;
      snp_ack_q <= 1'b0;
      snp_hit_q <= 1'b0;
      snp_dirty_q <= 1'b0;
    end else if (ce_i) begin
      snp_ack_q <= st == D_SNOOP;
      if (snp_take) begin
        snp_addr <= snoop_addr_i;
        snp_inv <= snoop_inv_i;
      end
      if (st == D_SNOOP) begin
        snp_hit_q <= snp_hit;
        snp_dirty_q <= snp_hit && tag_rdata_i[ENT_DIRTY];
      end
    end
  end

  // Tag entries hold valid, dirty and tag only; the arrays carry no parity bits.
  always_comb begin
    tag_we_o = 1'b0;
    tag_wdata_o = l2c_entry(1'b1, 1'b0, cur_addr[ADDR_W-1:TAG_LSB]);
    if ((st == D_BURST) && (beat == 2'h0) && cur_write && cfg_wb_mode_i) begin
      tag_we_o = 1'b1;
      tag_wdata_o = l2c_entry(1'b1, 1'b1, cur_addr[ADDR_W-1:TAG_LSB]);
    end else if ((st == D_MISS) && !cur_write && mem_ack_i && (beat == LAST_BEAT)) begin
      tag_we_o = 1'b1;
    end else if ((st == D_SNOOP) && snp_inv && snp_hit) begin
      tag_we_o = 1'b1;
      tag_wdata_o = l2c_entry(1'b0, 1'b0, snp_addr[ADDR_W-1:TAG_LSB]);
    end
  end

  // Read hits fetch one beat ahead so that processor data leaves from a flip-flop.
  assign sbeat = ((st == D_BURST) && !cur_write) ? beat + 2'h1 : beat;
  assign tag_addr_o = (st == D_SNOOP) ? l2c_index(snp_addr, cfg_size_i) : cur_idx;
  assign sram_addr_o = {cur_idx, sbeat};
  assign sram_we_o = ((st == D_BURST) && cur_write) || ((st == D_MISS) && !cur_write && mem_ack_i);
  assign sram_wdata_o = (st == D_MISS) ? mem_rdata_i : wdata_i;
  assign mem_wdata_o = (st == D_CAST) ? sram_rdata_i : wdata_i;
  assign mem_wvalid_o = (st == D_BURST) && cur_write && !cfg_wb_mode_i;
  assign mem_castout_o = st == D_CAST;
  assign mem_cast_addr_o = {vtag, cur_addr[TAG_LSB-1:LINE_LSB], 5'h00};
  assign mem_start_o = mem_start_q;
  assign mem_abort_o = mem_abort_q;
  assign mem_addr_o = cur_addr;
  assign mem_write_o = cur_write;
  assign ta_o = (st == D_BURST) || ((st == D_MISS) && cur_write && mem_ack_i) || rd_ack_q;
  assign rdata_o = rbuf;
  assign snoop_ack_o = snp_ack_q;
  assign snoop_hit_o = snp_hit_q;
  assign snoop_dirty_o = snp_dirty_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);

  parallel_start_a: assert property (start |=> mem_start_o && (st == D_LOOK))
    else $error("memory start not issued with lookup");
  hit_abort_a: assert property (decide && hit && !cur_write |=> mem_abort_o && ta_o)
    else $error("hit did not cancel memory cycle");
  np_lead_a: assert property ((st == D_IDLE) && start && (cfg_tag_wait_i == 4'h0) |=>
    !ta_o ##1 (!ta_o && decide) ##0 (!hit or (##1 ta_o [*4])))
    else $error("non-pipelined hit not 3-1-1-1");
  pipe_lead_a: assert property ((st == D_BURST) && last_beat && start && (cfg_tag_wait_i == 4'h0) |=>
    !ta_o && decide ##0 (!hit or (##1 ta_o [*4])))
    else $error("pipelined hit not 2-1-1-1");
  rd_then_wr_a: assert property ((st == D_BURST) && last_beat && !cur_write && pend_v && pend_write
    && (cfg_tag_wait_i == 4'h0) |=> cur_write && (st == D_LOOK) ##0 (!hit or (##1 (ta_o && sram_we_o) [*4])))
    else $error("read then pipelined write timing wrong");
  size_mask_a: assert property ((cfg_size_i == SIZE_256K) && (st != D_SNOOP) |->
    tag_addr_o[IDX_W-1:IDX_W-2] == 2'h0)
    else $error("index exceeds configured cache size");
  wb_dirty_a: assert property ((st == D_BURST) && (beat == 2'h0) && cur_write |->
    (tag_we_o && tag_wdata_o[ENT_DIRTY]) == cfg_wb_mode_i)
    else $error("write hit dirty marking does not follow mode");
  tag_wait_a: assert property (start |=> cnt == $past(cfg_tag_wait_i) + ($past(last_beat) ? 4'h1 : 4'h2))
    else $error("tag wait states not applied");
  snoop_ans_a: assert property ((st == D_IDLE) && snoop_req_i && !snoop_ack_o |=>
    (st == D_SNOOP) ##1 snoop_ack_o)
    else $error("snoop not answered in two cycles");
  one_ahead_a: assert property (pend_v |-> (bg_o == 2'h0) && !aack_o && arb_if.dbusy)
    else $error("more than one address outstanding");
  park_a: assert property ((br_i == 2'h0) && !pend_v && !arb_if.dbusy ##1 (br_i == 2'h0) && !pend_v
    && !arb_if.dbusy |-> (bg_o == (PARK_OWNER ? 2'h2 : 2'h1)) && (dbg_o == bg_o))
    else $error("buses not parked on default owner");
  wt_forward_a: assert property ((st == D_BURST) && cur_write && !cfg_wb_mode_i |->
    mem_wvalid_o && !mem_abort_o && !tag_we_o)
    else $error("write-through hit not forwarded");
  miss_data_a: assert property ((st == D_MISS) && !cur_write && mem_ack_i |=>
    ta_o && (rdata_o == $past(mem_rdata_i)))
    else $error("miss data not returned");
endmodule // l2c_ctrl

// >>> sim/l2c_far_model.sv
module l2c_far_model #(
  parameter int LEAD = 6
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [l2c_pkg::IDX_W-1:0] tag_addr_i,
  input wire logic tag_we_i,
  input wire logic [l2c_pkg::ENT_W-1:0] tag_wdata_i,
  output logic [l2c_pkg::ENT_W-1:0] tag_rdata_o,
  input wire logic [l2c_pkg::IDX_W+1:0] sram_addr_i,
  input wire logic sram_we_i,
  input wire logic [l2c_pkg::DATA_W-1:0] sram_wdata_i,
  output logic [l2c_pkg::DATA_W-1:0] sram_rdata_o,
  input wire logic mem_start_i,
  input wire logic mem_write_i,
  input wire logic mem_abort_i,
  input wire logic mem_castout_i,
  output logic mem_ack_o,
  output logic [l2c_pkg::DATA_W-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import l2c_pkg::*;
  logic [ENT_W-1:0] tag_ram [0:32767];
  logic [DATA_W-1:0] sram [0:131071];
  logic act;
  int cnt;
  logic [1:0] beat;

  // Tags start invalid so the first access to any line misses.
  initial for (int i = 0; i < 32768; i++) tag_ram[i] = '0;
  assign tag_rdata_o = tag_ram[tag_addr_i];
  assign sram_rdata_o = sram[sram_addr_i];
  always @(posedge clk_i) begin
    if (tag_we_i) tag_ram[tag_addr_i] <= tag_wdata_i;
    if (sram_we_i) sram[sram_addr_i] <= sram_wdata_i;
  end

  // The lead is longer than a hit decision with up to 4 tag wait states, so such an aborted access never acks.
  always @(posedge clk_i) begin
    if (!reset_n_i || mem_abort_i) begin
      act <= 1'b0;
    end else if (mem_start_i && !mem_write_i) begin
      act <= 1'b1;
      cnt <= LEAD;
      beat <= 2'h0;
    end else if (act && cnt > 0) begin
      cnt <= cnt - 1;
    end else if (act) begin
      beat <= beat + 2'h1;
      if (beat == 2'h3) act <= 1'b0;
    end
  end
  assign mem_ack_o = (act && cnt == 0) || mem_castout_i;
  // Outside an ack the data bus shows the inverse, never a stale beat.
  assign mem_rdata_o = mem_ack_o ? 64'hd000 + 64'(beat) : ~(64'hd000 + 64'(beat));
endmodule // l2c_far_model

// >>> sim/l2_cache_controller_parallel_lookup_tb.sv
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module l2_cache_controller_parallel_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import l2c_pkg::*;
  localparam logic [ADDR_W-1:0] LINE_A = 32'h100c_0040;
  logic clk_i, reset_n_i, cfg_wb, ts_i, write_i, aack_o, ta_o, tag_we, sram_we, mem_start, mem_write;
  logic mem_abort, mem_wvalid, castout, mem_ack, snoop_req, snoop_inv, snoop_ack, snoop_hit, snoop_dirty;
  logic [1:0] cfg_size, br_i, bg_o, dbg_o;
  logic [CNT_W-1:0] tag_wait;
  logic [ADDR_W-1:0] addr_i, snoop_addr, cast_addr, mem_addr;
  logic [DATA_W-1:0] rdata, wdata, sram_wd, sram_rd, mem_wd, mem_rd;
  logic [IDX_W-1:0] tag_addr;
  logic [ENT_W-1:0] tag_rd, tag_wd;
  logic [IDX_W+1:0] sram_addr;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int ts_q[$], ta_q[$], ab_q[$], ms_q[$];
  logic [IDX_W-1:0] tg_q[$];
  logic [DATA_W-1:0] rd_q[$], wd_q[$], wv_q[$], exp_q[$], cw_q[$];
  logic [ADDR_W-1:0] ca_q[$], ma_q[$];

  l2c_ctrl DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .cfg_wb_mode_i(cfg_wb),
    .cfg_size_i(cfg_size), .cfg_tag_wait_i(tag_wait), .br_i(br_i), .bg_o(bg_o), .dbg_o(dbg_o),
    .ts_i(ts_i), .addr_i(addr_i), .write_i(write_i), .aack_o(aack_o), .ta_o(ta_o), .rdata_o(rdata),
    .wdata_i(wdata), .tag_addr_o(tag_addr), .tag_rdata_i(tag_rd), .tag_we_o(tag_we), .tag_wdata_o(tag_wd),
    .sram_addr_o(sram_addr), .sram_we_o(sram_we), .sram_wdata_o(sram_wd), .sram_rdata_i(sram_rd),
    .mem_start_o(mem_start), .mem_addr_o(mem_addr), .mem_write_o(mem_write), .mem_abort_o(mem_abort),
    .mem_wvalid_o(mem_wvalid), .mem_castout_o(castout), .mem_cast_addr_o(cast_addr), .mem_wdata_o(mem_wd),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rd), .snoop_req_i(snoop_req), .snoop_addr_i(snoop_addr),
    .snoop_inv_i(snoop_inv), .snoop_ack_o(snoop_ack), .snoop_hit_o(snoop_hit), .snoop_dirty_o(snoop_dirty));
  l2c_far_model far (.clk_i(clk_i), .reset_n_i(reset_n_i), .tag_addr_i(tag_addr), .tag_we_i(tag_we),
    .tag_wdata_i(tag_wd), .tag_rdata_o(tag_rd), .sram_addr_i(sram_addr), .sram_we_i(sram_we),
    .sram_wdata_i(sram_wd), .sram_rdata_o(sram_rd), .mem_start_i(mem_start), .mem_write_i(mem_write),
    .mem_abort_i(mem_abort), .mem_castout_i(castout), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rd));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Sampled before the edge's own updates land, so every entry is a settled value.
  always @(posedge clk_i) begin
    cyc++;
    if (ts_i && aack_o) ts_q.push_back(cyc);
    if (ta_o) begin
      ta_q.push_back(cyc);
      rd_q.push_back(rdata);
      wd_q.push_back(wdata);
    end
    if (mem_start) begin
      ms_q.push_back(cyc);
      tg_q.push_back(tag_addr);
      ma_q.push_back(mem_addr);
    end
    if (mem_abort) ab_q.push_back(cyc);
    if (mem_wvalid) wv_q.push_back(mem_wd);
    if (castout) begin
      cw_q.push_back(mem_wd);
      ca_q.push_back(cast_addr);
    end
  end
  // Each beat carries fresh data so a lost or reordered beat shows.
  always @(posedge clk_i) if (ta_o) wdata <= wdata + 64'h1;

  task automatic clr;
    repeat (2) @(posedge clk_i);
    ts_q.delete(); ta_q.delete(); ab_q.delete(); ms_q.delete();
    tg_q.delete(); rd_q.delete(); wd_q.delete(); wv_q.delete();
    cw_q.delete(); ca_q.delete(); ma_q.delete();
  endtask
  task automatic waitn(input int n);
    for (int k = 0; k < 300 && ta_q.size() < n; k++) @(negedge clk_i);
  endtask
  task automatic issue(input logic [ADDR_W-1:0] a, input logic w);
    @(posedge clk_i);
    ts_i <= 1'b1;
    addr_i <= a;
    write_i <= w;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (aack_o === 1'b1) break;
    end
    ts_i <= 1'b0;
  endtask

  // The grant follows a request one edge later, since ownership is registered.
  task automatic t_arb;
    @(posedge clk_i) br_i <= 2'h2;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("grant_p1", 2'h2, bg_o)
    @(posedge clk_i) br_i <= 2'h0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("park_addr", 2'h1, bg_o)
    `CHK("park_data", 2'h1, dbg_o)
    @(posedge clk_i) br_i <= 2'h1;
    $display("test arbitration done");
  endtask
  task automatic t_read(input logic [ADDR_W-1:0] a, input int lead, input logic hit);
    int t0;
    clr();
    issue(a, 1'b0);
    waitn(4);
    t0 = ts_q[0];
    `CHK("mem_start", t0 + 1, ms_q[0])
    `CHK("tag_index", {2'h0, a[17:5]}, tg_q[0])
    `CHK("mem_addr", a, ma_q[0])
    `CHK("mem_abort", hit, ab_q.size() > 0)
    for (int i = 0; i < 4; i++) begin
      `CHK("rdata", exp_q[i], rd_q[i])
      if (hit) `CHK("hit_ta", t0 + lead + i, ta_q[i])
    end
    $display("test read hit=%0d lead=%0d done", hit, lead);
  endtask
  task automatic t_wt(input logic [ADDR_W-1:0] a);
    clr();
    cfg_wb <= 1'b0;
    issue(a, 1'b1);
    waitn(4);
    `CHK("wt_ta", ts_q[0] + 3, ta_q[0])
    `CHK("wt_fwd", 4, wv_q.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("wt_data", wd_q[i], wv_q[i])
      exp_q[i] = wd_q[i];
    end
    @(posedge clk_i) cfg_wb <= 1'b1;
    $display("test write-through done");
  endtask
  task automatic t_pipe(input logic [ADDR_W-1:0] a);
    clr();
    issue(a, 1'b0);
    issue(a, 1'b1);
    waitn(8);
    for (int i = 0; i < 8; i++) `CHK("pipe_ta", ts_q[0] + 3 + i + (i > 3 ? 1 : 0), ta_q[i])
    `CHK("wb_no_fwd", 0, wv_q.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("pipe_rd", exp_q[i], rd_q[i])
      exp_q[i] = wd_q[4 + i];
    end
    $display("test pipelined read-write done");
  endtask
  task automatic t_snoop(input logic [ADDR_W-1:0] a, input logic inv, input logic hit, input logic dirty);
    int k;
    @(posedge clk_i);
    snoop_req <= 1'b1;
    snoop_addr <= a;
    snoop_inv <= inv;
    for (k = 0; k < 10; k++) begin
      @(posedge clk_i);
      if (snoop_ack === 1'b1) break;
    end
    snoop_req <= 1'b0;
    `CHK("snoop_lat", 2, k)
    `CHK("snoop_hit", hit, snoop_hit)
    `CHK("snoop_dirty", dirty, snoop_dirty)
    $display("test snoop inv=%0d done", inv);
  endtask
  // A write-back hit dirties the line, then a read to the same index evicts it before the fill.
  task automatic t_cast(input logic [ADDR_W-1:0] b);
    clr();
    issue(LINE_A, 1'b1);
    waitn(4);
    for (int i = 0; i < 4; i++) exp_q[i] = wd_q[i];
    clr();
    issue(b, 1'b0);
    waitn(4);
    `CHK("cast_beats", 4, cw_q.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("cast_data", exp_q[i], cw_q[i])
      `CHK("cast_addr", LINE_A, ca_q[i])
      `CHK("fill_data", 64'hd000 + i, rd_q[i])
    end
    $display("test castout done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    end_sim();
  end
  initial begin
    reset_n_i = 1'b0;
    ts_i = 1'b0;
    addr_i = '0;
    write_i = 1'b0;
    br_i = 2'h1;
    cfg_wb = 1'b1;
    cfg_size = SIZE_256K;
    tag_wait = '0;
    snoop_req = 1'b0;
    snoop_addr = '0;
    snoop_inv = 1'b0;
    wdata = 64'hc0de0000;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_arb();
    exp_q = '{64'hd000, 64'hd001, 64'hd002, 64'hd003};
    t_read(LINE_A, 0, 1'b0);
    t_read(LINE_A, 3, 1'b1);
    @(posedge clk_i) tag_wait <= 4'h2;
    t_read(LINE_A, 5, 1'b1);
    @(posedge clk_i) tag_wait <= 4'h0;
    t_wt(LINE_A);
    t_snoop(LINE_A, 1'b0, 1'b1, 1'b0);
    t_pipe(LINE_A);
    t_read(LINE_A, 3, 1'b1);
    t_snoop(LINE_A, 1'b1, 1'b1, 1'b1);
    exp_q = '{64'hd000, 64'hd001, 64'hd002, 64'hd003};
    t_read(LINE_A, 0, 1'b0);
    t_cast(LINE_A ^ 32'h0004_0000);
    end_sim();
  end
endmodule // l2_cache_controller_parallel_lookup_tb
